// ===== design/fts_defines.vh
// constants of the frame timestamp capture block
`ifndef FTS_DEFINES_VH
`define FTS_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define FTS_OFF_CTRL 6'h00
`define FTS_OFF_EVENT_FLAG 6'h04
`define FTS_OFF_EVENT_MASK 6'h08
`define FTS_OFF_HELD_TX_STAMP 6'h0C
`define FTS_OFF_TIME_NOW 6'h10
`define FTS_ADDR_W 6

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define FTS_CTRL_ENABLE_BIT 0
`define FTS_EVT_W 2
`define FTS_EVT_STAMP_READY_BIT 0
`define FTS_EVT_RX_STAMP_BIT 1
`define FTS_STATUS_W 8
`define FTS_STATUS_REQ_BIT 5
`define FTS_SEQ_W 4
`define FTS_STAMP_W 32
`define FTS_RST_EVT 2'h0
`define FTS_RST_MASK 2'h0
`define FTS_RST_STAMP 32'h0
`define FTS_RST_SEQ 4'h0
`define FTS_RST_STATUS 8'h00
`define FTS_RST_DATA 32'h0
`define FTS_TIME_STEP 32'h1
`define FTS_SEQ_STEP 4'h1

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define FTS_RESP_OKAY 2'h0
`define FTS_RESP_DECERR 2'h3

`endif

// ===== design/fts_time_counter.v
// enable-gated 32-bit time counter shared by transmit and receive capture
`timescale 1ns/1ns
`default_nettype none
`include "fts_defines.vh"

module fts_time_counter (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire enable,
  // time
  output reg [`FTS_STAMP_W-1:0] time_now
);

  // holds its value while timestamping is off so stamps resume coherently
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      time_now <= `FTS_RST_STAMP;
    end else if (enable) begin
      time_now <= time_now + `FTS_TIME_STEP;
    end
  end

endmodule // fts_time_counter

`default_nettype wire

// ===== design/fts_capture.v
// frame timestamp capture unit with AXI4-Lite register slave
//
// Contract
// - all timestamping works only while the enable control bit is 1.
// - every transmitted frame returns a 32-bit stamp, a 4-bit sequence tag and its status.
// - status bit 5 is set exactly when the frame carried tx_stamp_request.
// - a flagged frame's stamp is also stored in held_tx_stamp.
// - storing a flagged stamp sets stamp_ready_flag in event_flag_reg.
// - unflagged frames neither overwrite held_tx_stamp nor set stamp_ready_flag.
// - each received frame latches the timer at start-of-frame delimiter detection.
// - the receive stamp is handed to the receive DMA for its descriptor.
// - writing one clears an event_flag_reg bit, zero leaves it, reset clears it; the code also clears the bits that a read of event_flag_reg returns.
// - the interrupt is raised while a flag bit and its mask bit are both set.
`timescale 1ns/1ns
`default_nettype none
`include "fts_defines.vh"

module fts_capture (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // axi4-lite write address and data
  input wire [`FTS_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [`FTS_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // transmit client side
  input wire tx_frame_sent,
  input wire tx_stamp_request,
  input wire [`FTS_STATUS_W-1:0] tx_frame_status,
  output reg tx_stamp_valid,
  output reg [`FTS_STAMP_W-1:0] tx_stamp_value,
  output reg [`FTS_SEQ_W-1:0] tx_frame_seq_tag,
  output reg [`FTS_STATUS_W-1:0] tx_stamp_status,
  // receive side
  input wire rx_sfd_detect,
  output reg rx_stamp_valid,
  output reg [`FTS_STAMP_W-1:0] rx_stamp_value,
  // interrupt
  output reg irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg precision_time_enable;
  reg [`FTS_EVT_W-1:0] event_flag_reg;
  reg [`FTS_EVT_W-1:0] event_mask_reg;
  reg [`FTS_STAMP_W-1:0] held_tx_stamp;
  reg [`FTS_SEQ_W-1:0] seq_count;
  reg [`FTS_STATUS_W-1:0] next_tx_status;
  wire [`FTS_STAMP_W-1:0] time_now;
  wire wr_fire;
  wire rd_fire;
  wire wr_lane0;
  wire tx_take;
  wire tx_flagged;
  wire rx_take;
  reg [`FTS_EVT_W-1:0] evt_set;
  reg [`FTS_EVT_W-1:0] evt_clr;
  reg [`FTS_EVT_W-1:0] next_event_flag;
  reg [31:0] next_rdata;
  reg next_rd_hit;

  // ------------------------------------------------------------
  // time base
  // ------------------------------------------------------------
  // one shared counter
  fts_time_counter u_time (
    .clk(clk),
    .rst_n(rst_n),
    .enable(precision_time_enable),
    .time_now(time_now)
  );

  assign tx_take = tx_frame_sent & precision_time_enable;
  assign tx_flagged = tx_take & tx_stamp_request;
  assign rx_take = rx_sfd_detect & precision_time_enable;

  // ------------------------------------------------------------
  // transmit stamp return
  // ------------------------------------------------------------
  // request bit reflects flag
  always @* begin
    next_tx_status = tx_frame_status;
    next_tx_status[`FTS_STATUS_REQ_BIT] = tx_stamp_request;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_stamp_valid <= 1'b0;
      tx_stamp_value <= `FTS_RST_STAMP;
      tx_frame_seq_tag <= `FTS_RST_SEQ;
      tx_stamp_status <= `FTS_RST_STATUS;
    end else begin
      tx_stamp_valid <= tx_take;
      if (tx_take) begin
        tx_stamp_value <= time_now;
        tx_frame_seq_tag <= seq_count;
        tx_stamp_status <= next_tx_status;
      end
    end
  end

  // tags count stamped frames only, so a disabled unit leaves no gap in the sequence
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_count <= `FTS_RST_SEQ;
    end else if (tx_take) begin
      seq_count <= seq_count + `FTS_SEQ_STEP;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_tx_stamp <= `FTS_RST_STAMP;
    end else if (tx_flagged) begin
      held_tx_stamp <= time_now;
    end
  end

  // ------------------------------------------------------------
  // receive stamp for the dma
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_stamp_valid <= 1'b0;
      rx_stamp_value <= `FTS_RST_STAMP;
    end else begin
      rx_stamp_valid <= rx_take;
      if (rx_take) begin
        rx_stamp_value <= time_now;
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  // both channels are taken together; the master holds each valid until then
  assign wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  // only byte lane 0 carries live bits; without it a write changes nothing
  assign wr_lane0 = wr_fire & s_axi_wstrb[0];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FTS_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (!s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        // the stamp and time offsets are read-only: a write there is answered okay and dropped
        case (s_axi_awaddr)
          `FTS_OFF_CTRL, `FTS_OFF_EVENT_FLAG, `FTS_OFF_EVENT_MASK,
          `FTS_OFF_HELD_TX_STAMP, `FTS_OFF_TIME_NOW: begin
            s_axi_bresp <= `FTS_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `FTS_RESP_DECERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      precision_time_enable <= 1'b0;
      event_mask_reg <= `FTS_RST_MASK;
    end else if (wr_lane0) begin
      if (s_axi_awaddr == `FTS_OFF_CTRL) begin
        precision_time_enable <= s_axi_wdata[`FTS_CTRL_ENABLE_BIT];
      end
      if (s_axi_awaddr == `FTS_OFF_EVENT_MASK) begin
        event_mask_reg <= s_axi_wdata[`FTS_EVT_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always @* begin
    next_rdata = `FTS_RST_DATA;
    next_rd_hit = 1'b1;
    case (s_axi_araddr)
      `FTS_OFF_CTRL: begin
        next_rdata[`FTS_CTRL_ENABLE_BIT] = precision_time_enable;
      end
      `FTS_OFF_EVENT_FLAG: begin
        next_rdata[`FTS_EVT_W-1:0] = event_flag_reg;
      end
      `FTS_OFF_EVENT_MASK: begin
        next_rdata[`FTS_EVT_W-1:0] = event_mask_reg;
      end
      // software reads the held stamp here
      `FTS_OFF_HELD_TX_STAMP: begin
        next_rdata = held_tx_stamp;
      end
      `FTS_OFF_TIME_NOW: begin
        next_rdata = time_now;
      end
      default: begin
        next_rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `FTS_RST_DATA;
      s_axi_rresp <= `FTS_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (!s_axi_arready && !s_axi_rvalid && s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rd_hit ? `FTS_RESP_OKAY : `FTS_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // event flags and interrupt
  // ------------------------------------------------------------
  always @* begin
    evt_set = `FTS_RST_EVT;
    evt_set[`FTS_EVT_STAMP_READY_BIT] = tx_flagged;
    evt_set[`FTS_EVT_RX_STAMP_BIT] = rx_take;
    evt_clr = `FTS_RST_EVT;
    if (wr_lane0 && s_axi_awaddr == `FTS_OFF_EVENT_FLAG) begin
      evt_clr = s_axi_wdata[`FTS_EVT_W-1:0];
    end
    // a read clears only the bits it returned, so nothing set later is lost
    if (rd_fire && s_axi_araddr == `FTS_OFF_EVENT_FLAG) begin
      evt_clr = evt_clr | event_flag_reg;
    end
    // set wins over clear in the same cycle
    next_event_flag = (event_flag_reg & ~evt_clr) | evt_set;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_flag_reg <= `FTS_RST_EVT;
      irq <= 1'b0;
    end else begin
      event_flag_reg <= next_event_flag;
      irq <= |(next_event_flag & event_mask_reg);
    end
  end

endmodule // fts_capture

`default_nettype wire

// ===== test/fts_monitor.sv
// assertions on the capture unit ports
`timescale 1ns/1ns
`default_nettype none
module fts_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched signals
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic irq,
  input wire logic tx_frame_sent,
  input wire logic tx_stamp_request,
  input wire logic [7:0] tx_frame_status,
  input wire logic tx_stamp_valid,
  input wire logic [31:0] tx_stamp_value,
  input wire logic [7:0] tx_stamp_status,
  input wire logic rx_sfd_detect,
  input wire logic rx_stamp_valid,
  input wire logic [31:0] rx_stamp_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_tx_cause: assert property (tx_stamp_valid |-> $past(tx_frame_sent))
    else $error("stray tx stamp");
  a_status_copy: assert property (
    tx_stamp_valid |-> (tx_stamp_status | 8'h20) == ($past(tx_frame_status) | 8'h20))
    else $error("status not passed");
  a_req_bit: assert property (
    tx_stamp_valid |-> tx_stamp_status[5] == $past(tx_stamp_request)) else $error("bit 5");
  a_rx_cause: assert property (rx_stamp_valid |-> $past(rx_sfd_detect))
    else $error("stray rx stamp");
  a_one_timer: assert property (
    tx_stamp_valid && rx_stamp_valid |-> tx_stamp_value == rx_stamp_value) else $error("timer");
  a_time_step: assert property (
    tx_stamp_valid ##1 tx_stamp_valid |-> tx_stamp_value == $past(tx_stamp_value) + 32'h1)
    else $error("time step");
  // irq is registered from the next flag value, so it rises with its cause or one edge on
  a_irq_rise: assert property (
    $rose(irq) |-> tx_stamp_valid && tx_stamp_status[5] || rx_stamp_valid || s_axi_bvalid
    || $past(s_axi_bvalid)) else $error("irq rise");
  a_irq_fall: assert property (
    $fell(irq) |-> s_axi_bvalid || s_axi_rvalid || $past(s_axi_bvalid) || $past(s_axi_rvalid))
    else $error("irq fall");
  c_flagged: cover property (tx_stamp_valid && tx_stamp_status[5]);
  c_both: cover property (tx_stamp_valid && rx_stamp_valid);
  c_irq_off: cover property ($fell(irq));
endmodule // fts_monitor
bind fts_capture fts_monitor u_monitor (.clk, .rst_n, .s_axi_bvalid, .s_axi_rvalid, .irq,
  .tx_frame_sent, .tx_stamp_request, .tx_frame_status, .tx_stamp_valid, .tx_stamp_value,
  .tx_stamp_status, .rx_sfd_detect, .rx_stamp_valid, .rx_stamp_value);
`default_nettype wire

// ===== test/fts_mac_model.sv
// transmit client and receive dma stand-in
`timescale 1ns/1ns
`default_nettype none
module fts_mac_model (
  // frame strobes to the unit
  input wire logic clk,
  output logic tx_frame_sent,
  output logic tx_stamp_request,
  output logic [7:0] tx_frame_status,
  output logic rx_sfd_detect,
  // stamps from the unit
  input wire logic tx_stamp_valid,
  input wire logic [31:0] tx_stamp_value,
  input wire logic [3:0] tx_frame_seq_tag,
  input wire logic [7:0] tx_stamp_status,
  input wire logic rx_stamp_valid,
  input wire logic [31:0] rx_stamp_value
);
  logic [43:0] rec_q[$];
  logic [31:0] desc_stamp = 32'h0;
  initial {tx_frame_sent, tx_stamp_request, tx_frame_status, rx_sfd_detect} = 11'h000;
  task send(input logic [3:0] req, input int n, input logic [7:0] st, input logic sfd);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      {tx_frame_sent, tx_stamp_request, tx_frame_status, rx_sfd_detect} <=
        {1'h1, req[i], st, sfd && i == 0};
    end
    // released lines flip so a stale copy cannot pass for a valid one
    @(posedge clk);
    {tx_frame_sent, tx_stamp_request, tx_frame_status, rx_sfd_detect} <=
      {1'h0, ~tx_stamp_request, ~st, 1'h0};
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (tx_stamp_valid)
      rec_q.push_back({tx_frame_seq_tag, tx_stamp_status, tx_stamp_value});
    if (rx_stamp_valid)
      desc_stamp <= rx_stamp_value;
  end
endmodule // fts_mac_model
`default_nettype wire

// ===== test/frame_timestamp_capture_test.sv
// self-checking bench for the frame timestamp capture unit
`timescale 1ns/1ns
`default_nettype none
`include "fts_defines.vh"
module frame_timestamp_capture_test;
  logic clk = 1'h0, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  int q_size;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, tx_stamp_value, rx_stamp_value;
  wire tx_frame_sent, tx_stamp_request, rx_sfd_detect, tx_stamp_valid, rx_stamp_valid;
  wire [7:0] tx_frame_status, tx_stamp_status;
  wire [3:0] tx_frame_seq_tag;
  int num_errors = 0, checked = 0;
  fts_capture DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tx_frame_sent, .tx_stamp_request, .tx_frame_status, .tx_stamp_valid,
    .tx_stamp_value, .tx_frame_seq_tag, .tx_stamp_status, .rx_sfd_detect, .rx_stamp_valid,
    .rx_stamp_value, .irq);
  fts_mac_model mac (.clk, .tx_frame_sent, .tx_stamp_request, .tx_frame_status, .rx_sfd_detect,
    .tx_stamp_valid, .tx_stamp_value, .tx_frame_seq_tag, .tx_stamp_status, .rx_stamp_valid,
    .rx_stamp_value);
  initial forever #5 clk = ~clk;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // settle two edges after the answer so irq has caught up
  task wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    check(s_axi_bresp, a > `FTS_OFF_TIME_NOW ? `FTS_RESP_DECERR : `FTS_RESP_OKAY);
    repeat (2) @(posedge clk);
  endtask
  task rd_val(input logic [5:0] a, output logic [31:0] d, output logic [1:0] e);
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    e = s_axi_rresp;
  endtask
  task rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] e;
    rd_val(a, d, e);
    check(d, exp);
    check(e, a > `FTS_OFF_TIME_NOW ? `FTS_RESP_DECERR : `FTS_RESP_OKAY);
  endtask
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rd(`FTS_OFF_EVENT_FLAG, 32'h0);
    mac.send(4'h1, 1, 8'h00, 1'h1);
    check(mac.rec_q.size(), 32'h0);
    wr(`FTS_OFF_CTRL, 32'h1);
    wr(`FTS_OFF_EVENT_MASK, 32'h3);
    mac.send(4'h2, 2, 8'hFF, 1'h1);
    check(mac.rec_q[0][43:32], 32'h0DF);
    check(mac.rec_q[1][43:32], 32'h1FF);
    check(mac.rec_q[1][31:0], mac.rec_q[0][31:0] + 32'h1);
    check(mac.desc_stamp, mac.rec_q[0][31:0]);
    check(irq, 1'h1);
    rd(`FTS_OFF_HELD_TX_STAMP, mac.rec_q[1][31:0]);
    rd(`FTS_OFF_EVENT_FLAG, 32'h3);
    mac.send(4'h0, 1, 8'h00, 1'h0);
    rd(`FTS_OFF_HELD_TX_STAMP, mac.rec_q[1][31:0]);
    rd(`FTS_OFF_EVENT_FLAG, 32'h0);
    mac.send(4'h1, 1, 8'h00, 1'h0);
    wr(`FTS_OFF_EVENT_FLAG, 32'h0);
    check(irq, 1'h1);
    wr(`FTS_OFF_EVENT_FLAG, 32'h1);
    check(irq, 1'h0);
    wr(`FTS_OFF_EVENT_MASK, 32'h0);
    mac.send(4'h1, 1, 8'h00, 1'h0);
    check(irq, 1'h0);
    // software handshake: wait for the ready flag, then fetch the held stamp
    do begin
      rd_val(`FTS_OFF_EVENT_FLAG, rd_data, rd_resp);
    end while (!rd_data[0]);
    rd(`FTS_OFF_HELD_TX_STAMP, mac.rec_q[mac.rec_q.size() - 1][31:0]);
    s_axi_wstrb <= 4'h0;
    wr(`FTS_OFF_CTRL, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(`FTS_OFF_CTRL, 32'h1);
    wr(6'h14, 32'h1);
    mac.send(4'h1, 1, 8'h00, 1'h1);
    // a second reset in mid-run must clear the pending flags and the enable
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rd(`FTS_OFF_EVENT_FLAG, 32'h0);
    rd(`FTS_OFF_CTRL, 32'h0);
    q_size = mac.rec_q.size();
    mac.send(4'h1, 1, 8'h00, 1'h1);
    check(mac.rec_q.size(), q_size);
    rd(`FTS_OFF_TIME_NOW, 32'h0);
    rd(`FTS_OFF_EVENT_FLAG, 32'h0);
    rd(6'h14, 32'h0);
    end_of_test;
  end
endmodule // frame_timestamp_capture_test
`default_nettype wire
